// ==== core/phy_test_defines.svh ====
`ifndef PHY_TEST_DEFINES_SVH
`define PHY_TEST_DEFINES_SVH

// Register indices; byte address is four times the index
`define IDX_PKT_LEN       10'h07B
`define IDX_GAP_LEN       10'h07C
`define IDX_DELAY_CTL     10'h086
`define IDX_EQ_CFG        10'h08A
`define IDX_GAIN_AB       10'h0A0
`define IDX_GAIN_CD       10'h0A1
`define IDX_SWING_AB      10'h0A2
`define IDX_GEN_CTL       10'h0F0
`define IDX_GEN_STS       10'h0F1

// Reset values
`define RST_PKT_LEN       16'h05DC
`define RST_GAP_LEN       16'h007D
`define RST_EQ_CFG        16'h0000
`define RST_SWING_AB      16'h0810
`define RST_GEN_CTL       16'h0000

// Writable bits of each register
`define MASK_PKT_LEN      16'hFFFF
`define MASK_GAP_LEN      16'h00FF
`define MASK_DELAY_CTL    16'h00FF
`define MASK_EQ_CFG       16'hFFFF
`define MASK_GAIN         16'h0F0F
`define MASK_SWING        16'h3F3F
`define MASK_GEN_CTL      16'h0001

// Field positions
`define TX_DELAY_MSB      7
`define TX_DELAY_LSB      4
`define RX_DELAY_MSB      3
`define RX_DELAY_LSB      0
`define GAIN_LO_MSB       3
`define GAIN_LO_LSB       0
`define GAIN_HI_MSB       11
`define GAIN_HI_LSB       8
`define SWING_A_MSB       4
`define SWING_A_LSB       0
`define SWING_A_FORCE     5
`define SWING_B_MSB       12
`define SWING_B_LSB       8
`define SWING_B_FORCE     13
`define GEN_ENABLE_BIT    0
`define GAP_UNITS_MSB     7
`define GAP_UNITS_LSB     0

// Behaviour constants
`define SWING_INTERNAL    5'h10
`define GAIN_CENTER       8'sh08
`define GAIN_STEP_PCT     8'sh02
`define PREAMBLE_NIBBLES  5'h0D
`define PREAMBLE_NIBBLE   4'h5
`define SFD_LOW_NIBBLE    4'h5
`define SFD_HIGH_NIBBLE   4'hD
`define GAP_NIBBLE_SHIFT  3
`define LFSR_SEED         15'h7FFF
`define LOAD_DONE_STAGE   2'h2

`endif

// ==== core/phy_test_pkg.sv ====
package phy_test_pkg;

	typedef enum logic [4:0] {
		GEN_IDLE     = 5'b00001,
		GEN_PREAMBLE = 5'b00010,
		GEN_SFD      = 5'b00100,
		GEN_PAYLOAD  = 5'b01000,
		GEN_GAP      = 5'b10000
	} gen_state_t;

	typedef logic [15:0] reg16_t;

endpackage : phy_test_pkg

// ==== core/selftest_if.sv ====
`timescale 1ns/1ps
`default_nettype none

interface selftest_if;
	logic                    enable;
	logic [15:0]             packet_bytes;
	logic [7:0]              gap_units;
	logic                    busy;
	phy_test_pkg::gen_state_t phase;
	logic [11:0]             packets_sent;

	modport regs (output enable, output packet_bytes, output gap_units,
		input busy, input phase, input packets_sent);
	modport gen (input enable, input packet_bytes, input gap_units,
		output busy, output phase, output packets_sent);
endinterface : selftest_if

`default_nettype wire

// ==== core/selftest_gen.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "phy_test_defines.svh"

module selftest_gen (
	input  wire logic   clk_sys,
	input  wire logic   sys_rst,
	selftest_if.gen     cfg,
	output logic [3:0]  gen_nibble,
	output logic        gen_valid
);

	phy_test_pkg::gen_state_t state;
	phy_test_pkg::gen_state_t next_state;
	logic [16:0]  count;
	logic [16:0]  next_count;
	logic [14:0]  lfsr;
	logic [16:0]  payload_last;
	logic [16:0]  gap_last;
	logic         payload_empty;
	logic         gap_empty;
	logic         count_done_pre;
	logic         count_done_pay;
	logic         count_done_gap;
	logic [3:0]   next_nibble;

	assign payload_last   = {cfg.packet_bytes, 1'b0} - 17'h00001;
	assign gap_last       = 17'({cfg.gap_units, 3'b000}) - 17'h00001;
	assign payload_empty  = (cfg.packet_bytes == 16'h0000);
	assign gap_empty      = (cfg.gap_units == 8'h00);
	assign count_done_pre = (count == 17'({`PREAMBLE_NIBBLES}) - 17'h00001);
	assign count_done_pay = (count == payload_last);
	assign count_done_gap = (count == gap_last);

	always_comb begin
		next_state = state;
		next_count = count + 17'h00001;
		unique case (state)
			phy_test_pkg::GEN_IDLE: begin
				next_count = 17'h00000;
				if (cfg.enable) begin
					next_state = phy_test_pkg::GEN_PREAMBLE;
				end
			end
			phy_test_pkg::GEN_PREAMBLE: begin
				if (count_done_pre) begin
					next_state = phy_test_pkg::GEN_SFD;
					next_count = 17'h00000;
				end
			end
			phy_test_pkg::GEN_SFD: begin
				if (count[0]) begin
					next_count = 17'h00000;
					next_state = payload_empty ? phy_test_pkg::GEN_GAP : phy_test_pkg::GEN_PAYLOAD;
					if (payload_empty && gap_empty) begin
						next_state = cfg.enable ? phy_test_pkg::GEN_PREAMBLE : phy_test_pkg::GEN_IDLE;
					end
				end
			end
			phy_test_pkg::GEN_PAYLOAD: begin
				if (count_done_pay) begin
					next_count = 17'h00000;
					next_state = phy_test_pkg::GEN_GAP;
					if (gap_empty) begin
						next_state = cfg.enable ? phy_test_pkg::GEN_PREAMBLE : phy_test_pkg::GEN_IDLE;
					end
				end
			end
			phy_test_pkg::GEN_GAP: begin
				if (count_done_gap) begin
					next_count = 17'h00000;
					next_state = cfg.enable ? phy_test_pkg::GEN_PREAMBLE : phy_test_pkg::GEN_IDLE;
				end
			end
			default: begin
				next_state = phy_test_pkg::GEN_IDLE;
				next_count = 17'h00000;
			end
		endcase
	end

	always_comb begin
		unique case (next_state)
			phy_test_pkg::GEN_PREAMBLE: next_nibble = `PREAMBLE_NIBBLE;
			phy_test_pkg::GEN_SFD:      next_nibble = next_count[0] ? `SFD_HIGH_NIBBLE : `SFD_LOW_NIBBLE;
			phy_test_pkg::GEN_PAYLOAD:  next_nibble = lfsr[3:0];
			default:                    next_nibble = 4'h0;
		endcase
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			state      <= phy_test_pkg::GEN_IDLE;
			count      <= 17'h00000;
			lfsr       <= `LFSR_SEED;
			gen_nibble <= 4'h0;
			gen_valid  <= 1'b0;
		end else begin
			state      <= next_state;
			count      <= next_count;
			gen_nibble <= next_nibble;
			gen_valid  <= (next_state != phy_test_pkg::GEN_IDLE) && (next_state != phy_test_pkg::GEN_GAP);
			if (next_state == phy_test_pkg::GEN_PAYLOAD) begin
				lfsr <= {lfsr[13:0], lfsr[14] ^ lfsr[13]};
			end
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			cfg.packets_sent <= 12'h000;
		end else if (state == phy_test_pkg::GEN_SFD && count[0]) begin
			cfg.packets_sent <= cfg.packets_sent + 12'h001;
		end
	end

	assign cfg.busy  = (state != phy_test_pkg::GEN_IDLE);
	assign cfg.phase = state;

endmodule : selftest_gen

`default_nettype wire

// ==== core/phy_test_delay_trim_regs.sv ====
// How it works
// - The self-test packet length is a 16-bit setting in bytes that resets to 1500.
// - Every generated packet starts with thirteen 0x5 nibbles and then the 0xD5 delimiter.
// - An 8-bit gap setting, reset to 0x7D, sets the idle length between successive packets.
// - The idle gap between packets lasts four bytes per unit of the gap setting.
// - Bits 15:8 of the clock delay register ignore writes and read as zero.
// - The 4-bit transmit delay code selects (code+1) quarter nanoseconds of clock delay.
// - The 4-bit receive delay code selects (code+1) quarter nanoseconds of clock delay.
// - Both delay fields load from the strap pins at reset and stay writable afterwards.
// - Each channel has a writable 4-bit fine gain field loaded from trim at reset.
// - Fine gain codes map to 2% steps, code 8 being no change and code 0 giving -16%.
// - Channels B, C and D share the gain mapping of channel A.
// - Channel A swing value drives the line only while its override bit is set.
// - Channel B swing works the same way, and both fields reset to their defaults.
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "phy_test_defines.svh"

module phy_test_delay_trim_regs (
	input  wire logic         clk_sys,
	input  wire logic         sys_rst,
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [11:0]  paddr,
	input  wire logic [31:0]  pwdata,
	input  wire logic [3:0]   pstrb,
	output logic [31:0]       prdata,
	output logic              pready,
	output logic              pslverr,
	input  wire logic [2:0]   strap_tx_delay,
	input  wire logic [2:0]   strap_rx_delay,
	input  wire logic [15:0]  trim_fine_gain,
	output logic [4:0]        tx_delay_quarter_ns,
	output logic [4:0]        rx_delay_quarter_ns,
	output logic [3:0]        fine_gain_chan_a,
	output logic [3:0]        fine_gain_chan_b,
	output logic [3:0]        fine_gain_chan_c,
	output logic [3:0]        fine_gain_chan_d,
	output logic [31:0]       fine_gain_pct,
	output logic [4:0]        driver_swing_chan_a,
	output logic [4:0]        driver_swing_chan_b,
	output logic [15:0]       rx_equalizer_setting,
	output logic [3:0]        gen_nibble,
	output logic              gen_valid
);

	// Merge write data into a register, honouring byte strobes and writable bits
	function automatic phy_test_pkg::reg16_t merge_write(
		input phy_test_pkg::reg16_t old_value,
		input logic [15:0]          wdata,
		input logic [1:0]           strb,
		input logic [15:0]          writable
	);
		logic [15:0] lanes;
		lanes = {{8{strb[1]}}, {8{strb[0]}}} & writable;
		merge_write = (old_value & ~lanes) | (wdata & lanes);
	endfunction : merge_write

	// Delay code to quarter nanoseconds
	function automatic logic [4:0] delay_quarters(input logic [3:0] code);
		delay_quarters = 5'({1'b0, code}) + 5'h01;
	endfunction : delay_quarters

	// Fine gain code to signed percent change
	function automatic logic signed [7:0] gain_percent(input logic [3:0] code);
		gain_percent = (8'(signed'({4'h0, code})) - `GAIN_CENTER) * `GAIN_STEP_PCT;
	endfunction : gain_percent

	// Register index compare shared by every select
	function automatic logic index_hit(input logic [9:0] index, input logic [9:0] target);
		index_hit = (index == target);
	endfunction : index_hit

	selftest_if gen_link ();

	// Strap and trim synchronisers
	logic [21:0]  pin_sync_a;
	logic [21:0]  pin_sync_b;
	logic [1:0]   load_stage;
	logic         loaded;
	logic         load_now;
	logic [2:0]   strap_tx_sync;
	logic [2:0]   strap_rx_sync;
	logic [3:0]   trim_gain_a;
	logic [3:0]   trim_gain_b;
	logic [3:0]   trim_gain_c;
	logic [3:0]   trim_gain_d;
	logic [15:0]  delay_strap_word;
	logic [15:0]  gain_ab_trim;
	logic [15:0]  gain_cd_trim;

	// Register storage
	phy_test_pkg::reg16_t  pkt_len;
	phy_test_pkg::reg16_t  gap_len;
	phy_test_pkg::reg16_t  delay_ctl;
	phy_test_pkg::reg16_t  eq_cfg;
	phy_test_pkg::reg16_t  gain_ab;
	phy_test_pkg::reg16_t  gain_cd;
	phy_test_pkg::reg16_t  swing_ab;
	phy_test_pkg::reg16_t  gen_ctl;

	// Bus decode
	logic [9:0]   reg_index;
	logic         aligned;
	logic         hit_pkt_len;
	logic         hit_gap_len;
	logic         hit_delay_ctl;
	logic         hit_eq_cfg;
	logic         hit_gain_ab;
	logic         hit_gain_cd;
	logic         hit_swing_ab;
	logic         hit_gen_ctl;
	logic         hit_gen_sts;
	logic         mapped;
	logic         access_done;
	logic         wr_en;
	logic [1:0]   wr_strb;
	logic [15:0]  wr_data;
	logic [15:0]  read_value;
	logic [15:0]  gen_status;
	logic [31:0]  next_prdata;
	logic         rd_en;

	// Write strobes per register
	logic         wr_delay_ctl;
	logic         wr_eq_cfg;
	logic         wr_swing_ab;
	logic         wr_gain_ab;
	logic         wr_gain_cd;

	// Generator status fields
	logic         gen_busy;
	logic [11:0]  gen_packets;

	// Named fields of the settings
	logic [15:0]  selftest_packet_bytes;
	logic [7:0]   selftest_gap_units;
	logic         swing_override_chan_a;
	logic         swing_override_chan_b;
	logic [4:0]   swing_field_chan_a;
	logic [4:0]   swing_field_chan_b;

	assign reg_index     = paddr[11:2];
	assign aligned       = (paddr[1:0] == 2'b00);
	assign hit_pkt_len   = aligned && index_hit(reg_index, `IDX_PKT_LEN);
	assign hit_gap_len   = aligned && index_hit(reg_index, `IDX_GAP_LEN);
	assign hit_delay_ctl = aligned && index_hit(reg_index, `IDX_DELAY_CTL);
	assign hit_eq_cfg    = aligned && index_hit(reg_index, `IDX_EQ_CFG);
	assign hit_gain_ab   = aligned && index_hit(reg_index, `IDX_GAIN_AB);
	assign hit_gain_cd   = aligned && index_hit(reg_index, `IDX_GAIN_CD);
	assign hit_swing_ab  = aligned && index_hit(reg_index, `IDX_SWING_AB);
	assign hit_gen_ctl   = aligned && index_hit(reg_index, `IDX_GEN_CTL);
	assign hit_gen_sts   = aligned && index_hit(reg_index, `IDX_GEN_STS);
	assign mapped        = hit_pkt_len | hit_gap_len | hit_delay_ctl | hit_eq_cfg | hit_gain_ab
		| hit_gain_cd | hit_swing_ab | hit_gen_ctl | hit_gen_sts;

	// Answer only after straps and trim are in place
	assign pready      = psel && penable && loaded;
	assign pslverr     = pready && !mapped;
	assign access_done = pready;
	assign wr_en       = access_done && pwrite && mapped;
	assign wr_strb     = pstrb[1:0];
	assign wr_data     = pwdata[15:0];
	assign rd_en       = psel && !pwrite;

	// Write strobes per register
	assign wr_delay_ctl = wr_en && hit_delay_ctl;
	assign wr_eq_cfg    = wr_en && hit_eq_cfg;
	assign wr_swing_ab  = wr_en && hit_swing_ab;
	assign wr_gain_ab   = wr_en && hit_gain_ab;
	assign wr_gain_cd   = wr_en && hit_gain_cd;

	// Generator status word, busy flag over the packet count
	assign gen_busy    = gen_link.busy;
	assign gen_packets = gen_link.packets_sent;
	assign gen_status  = {3'b000, gen_busy, gen_packets};

	assign read_value =
		({16{hit_pkt_len}}   & pkt_len)   |
		({16{hit_gap_len}}   & gap_len)   |
		({16{hit_delay_ctl}} & delay_ctl) |
		({16{hit_eq_cfg}}    & eq_cfg)    |
		({16{hit_gain_ab}}   & gain_ab)   |
		({16{hit_gain_cd}}   & gain_cd)   |
		({16{hit_swing_ab}}  & swing_ab)  |
		({16{hit_gen_ctl}}   & gen_ctl)   |
		({16{hit_gen_sts}}   & gen_status);

	assign next_prdata = rd_en ? {16'h0000, read_value} : 32'h0000_0000;

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			prdata <= 32'h0000_0000;
		end else begin
			prdata <= next_prdata;
		end
	end

	// Two-flop synchroniser for straps and trim pins
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			pin_sync_a <= 22'h000000;
			pin_sync_b <= 22'h000000;
		end else begin
			pin_sync_a <= {strap_tx_delay, strap_rx_delay, trim_fine_gain};
			pin_sync_b <= pin_sync_a;
		end
	end

	// Synchronised pin groups and the register words they seed
	assign {strap_tx_sync, strap_rx_sync, trim_gain_d, trim_gain_c, trim_gain_b, trim_gain_a} = pin_sync_b;
	assign delay_strap_word = {8'h00, 1'b0, strap_tx_sync, 1'b0, strap_rx_sync};
	assign gain_ab_trim     = {4'h0, trim_gain_b, 4'h0, trim_gain_a};
	assign gain_cd_trim     = {4'h0, trim_gain_d, 4'h0, trim_gain_c};

	// Capture straps once after reset release
	assign load_now = !loaded && (load_stage == `LOAD_DONE_STAGE);

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			load_stage <= 2'h0;
			loaded     <= 1'b0;
		end else if (!loaded) begin
			load_stage <= load_stage + 2'h1;
			loaded     <= load_now;
		end
	end

	// Self-test settings
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			pkt_len <= `RST_PKT_LEN;
			gap_len <= `RST_GAP_LEN;
			gen_ctl <= `RST_GEN_CTL;
		end else if (wr_en) begin
			if (hit_pkt_len) begin
				pkt_len <= merge_write(pkt_len, wr_data, wr_strb, `MASK_PKT_LEN);
			end
			if (hit_gap_len) begin
				gap_len <= merge_write(gap_len, wr_data, wr_strb, `MASK_GAP_LEN);
			end
			if (hit_gen_ctl) begin
				gen_ctl <= merge_write(gen_ctl, wr_data, wr_strb, `MASK_GEN_CTL);
			end
		end
	end

	// Clock delay control, loaded from straps
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			delay_ctl <= 16'h0000;
		end else if (load_now) begin
			delay_ctl <= delay_strap_word;
		end else if (wr_delay_ctl) begin
			delay_ctl <= merge_write(delay_ctl, wr_data, wr_strb, `MASK_DELAY_CTL);
		end
	end

	// Receiver equalizer setting
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			eq_cfg <= `RST_EQ_CFG;
		end else if (wr_eq_cfg) begin
			eq_cfg <= merge_write(eq_cfg, wr_data, wr_strb, `MASK_EQ_CFG);
		end
	end

	// Fine gain, loaded from trim
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			gain_ab <= 16'h0000;
			gain_cd <= 16'h0000;
		end else if (load_now) begin
			gain_ab <= gain_ab_trim;
			gain_cd <= gain_cd_trim;
		end else begin
			if (wr_gain_ab) begin
				gain_ab <= merge_write(gain_ab, wr_data, wr_strb, `MASK_GAIN);
			end
			if (wr_gain_cd) begin
				gain_cd <= merge_write(gain_cd, wr_data, wr_strb, `MASK_GAIN);
			end
		end
	end

	// Line driver swing override
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			swing_ab <= `RST_SWING_AB;
		end else if (wr_swing_ab) begin
			swing_ab <= merge_write(swing_ab, wr_data, wr_strb, `MASK_SWING);
		end
	end

	// Outputs towards the analogue and clocking blocks
	assign tx_delay_quarter_ns = delay_quarters(delay_ctl[`TX_DELAY_MSB:`TX_DELAY_LSB]);
	assign rx_delay_quarter_ns = delay_quarters(delay_ctl[`RX_DELAY_MSB:`RX_DELAY_LSB]);
	assign rx_equalizer_setting = eq_cfg;

	assign fine_gain_chan_a = gain_ab[`GAIN_LO_MSB:`GAIN_LO_LSB];
	assign fine_gain_chan_b = gain_ab[`GAIN_HI_MSB:`GAIN_HI_LSB];
	assign fine_gain_chan_c = gain_cd[`GAIN_LO_MSB:`GAIN_LO_LSB];
	assign fine_gain_chan_d = gain_cd[`GAIN_HI_MSB:`GAIN_HI_LSB];

	// Same percent mapping for all four channels
	logic [15:0] gain_codes;
	assign gain_codes = {fine_gain_chan_d, fine_gain_chan_c, fine_gain_chan_b, fine_gain_chan_a};

	genvar ch;
	generate
		for (ch = 0; ch < 4; ch = ch + 1) begin : g_gain_pct
			assign fine_gain_pct[ch*8 +: 8] = gain_percent(gain_codes[ch*4 +: 4]);
		end
	endgenerate

	assign swing_override_chan_a = swing_ab[`SWING_A_FORCE];
	assign swing_override_chan_b = swing_ab[`SWING_B_FORCE];
	assign swing_field_chan_a    = swing_ab[`SWING_A_MSB:`SWING_A_LSB];
	assign swing_field_chan_b    = swing_ab[`SWING_B_MSB:`SWING_B_LSB];
	assign driver_swing_chan_a   = swing_override_chan_a ? swing_field_chan_a : `SWING_INTERNAL;
	assign driver_swing_chan_b   = swing_override_chan_b ? swing_field_chan_b : `SWING_INTERNAL;

	// Self-test generator
	assign selftest_packet_bytes = pkt_len;
	assign selftest_gap_units    = gap_len[`GAP_UNITS_MSB:`GAP_UNITS_LSB];
	assign gen_link.enable       = gen_ctl[`GEN_ENABLE_BIT];
	assign gen_link.packet_bytes = selftest_packet_bytes;
	assign gen_link.gap_units    = selftest_gap_units;

	selftest_gen u_selftest_gen (
		.clk_sys    (clk_sys),
		.sys_rst    (sys_rst),
		.cfg        (gen_link),
		.gen_nibble (gen_nibble),
		.gen_valid  (gen_valid)
	);

endmodule : phy_test_delay_trim_regs

`default_nettype wire

// ==== testbench/phy_test_checker.sv ====
`timescale 1ns/1ps
`default_nettype none

module phy_test_checker (
	input wire logic        clk_sys,
	input wire logic        sys_rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic [4:0]  tx_delay_quarter_ns,
	input wire logic [4:0]  rx_delay_quarter_ns,
	input wire logic [3:0]  fine_gain_chan_a,
	input wire logic [3:0]  fine_gain_chan_b,
	input wire logic [3:0]  fine_gain_chan_c,
	input wire logic [3:0]  fine_gain_chan_d,
	input wire logic [31:0] fine_gain_pct,
	input wire logic [4:0]  driver_swing_chan_a,
	input wire logic [4:0]  driver_swing_chan_b,
	input wire logic [3:0]  gen_nibble,
	input wire logic        gen_valid
);
	// Completed read in this cycle
	wire rd_hit = psel & penable & pready & ~pwrite;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	a_delay_resv_zero: assert property (rd_hit && paddr == 12'h218 |-> prdata[15:8] == 8'h00)
		else $error("delay reserved bits not zero");
	a_tx_delay_map: assert property (rd_hit && paddr == 12'h218 |->
		tx_delay_quarter_ns == {1'b0, prdata[7:4]} + 5'h01)
		else $error("tx delay output mismatch");
	a_rx_delay_map: assert property (rd_hit && paddr == 12'h218 |->
		rx_delay_quarter_ns == {1'b0, prdata[3:0]} + 5'h01)
		else $error("rx delay output mismatch");
	a_gap_resv_zero: assert property (rd_hit && paddr == 12'h1F0 |-> prdata[15:8] == 8'h00)
		else $error("gap reserved bits not zero");
	a_gain_a_pct: assert property (fine_gain_pct[7:0] == ({4'h0, fine_gain_chan_a} - 8'h08) * 8'h02)
		else $error("channel a gain percent wrong");
	a_gain_bcd_pct: assert property (fine_gain_pct[15:8] == ({4'h0, fine_gain_chan_b} - 8'h08) * 8'h02
		&& fine_gain_pct[23:16] == ({4'h0, fine_gain_chan_c} - 8'h08) * 8'h02
		&& fine_gain_pct[31:24] == ({4'h0, fine_gain_chan_d} - 8'h08) * 8'h02)
		else $error("channel b c d gain percent wrong");
	a_swing_a_sel: assert property (rd_hit && paddr == 12'h288 |->
		driver_swing_chan_a == (prdata[5] ? prdata[4:0] : 5'h10))
		else $error("channel a swing selection wrong");
	a_swing_b_sel: assert property (rd_hit && paddr == 12'h288 |->
		driver_swing_chan_b == (prdata[13] ? prdata[12:8] : 5'h10))
		else $error("channel b swing selection wrong");
	a_preamble_sfd: assert property ($rose(gen_valid) |-> (gen_valid && gen_nibble == 4'h5)[*7]
		##1 (gen_valid && gen_nibble == 4'h5)[*7] ##1 (gen_valid && gen_nibble == 4'hD))
		else $error("preamble or delimiter wrong");
endmodule : phy_test_checker

bind phy_test_delay_trim_regs phy_test_checker u_chk (.clk_sys, .sys_rst, .psel, .penable, .pwrite, .paddr,
	.prdata, .pready, .tx_delay_quarter_ns, .rx_delay_quarter_ns, .fine_gain_chan_a, .fine_gain_chan_b,
	.fine_gain_chan_c, .fine_gain_chan_d, .fine_gain_pct, .driver_swing_chan_a, .driver_swing_chan_b,
	.gen_nibble, .gen_valid);

`default_nettype wire

// ==== testbench/phy_test_delay_trim_regs_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_total++; $display("[ERR] %s exp %h got %h", nm, e, g); end end

module phy_test_delay_trim_regs_tb;
	logic        clk_sys = 1'b0;
	logic        sys_rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [3:0]  pstrb = 4'h0;
	logic [2:0]  strap_tx_delay = 3'h5;
	logic [2:0]  strap_rx_delay = 3'h2;
	logic [15:0] trim_fine_gain = 16'h9F08;
	logic [31:0] prdata, fine_gain_pct, rd;
	logic        pready, pslverr, gen_valid, serr;
	logic [4:0]  tx_delay_quarter_ns, rx_delay_quarter_ns, driver_swing_chan_a, driver_swing_chan_b;
	logic [3:0]  fine_gain_chan_a, fine_gain_chan_b, fine_gain_chan_c, fine_gain_chan_d, gen_nibble;
	logic [15:0] rx_equalizer_setting;
	int          err_total = 0;
	int          checks = 0;
	int          n, vlen, glen, bad;
	logic [11:0] ra [7] = '{12'h1EC, 12'h1F0, 12'h218, 12'h228, 12'h280, 12'h284, 12'h288};
	logic [15:0] rv [7] = '{16'h05DC, 16'h007D, 16'h0052, 16'h0000, 16'h0008, 16'h090F, 16'h0810};
	logic [15:0] wm [7] = '{16'hFFFF, 16'h00FF, 16'h00FF, 16'hFFFF, 16'h0F0F, 16'h0F0F, 16'h3F3F};

	phy_test_delay_trim_regs uut (.clk_sys, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .strap_tx_delay, .strap_rx_delay, .trim_fine_gain, .tx_delay_quarter_ns,
		.rx_delay_quarter_ns, .fine_gain_chan_a, .fine_gain_chan_b, .fine_gain_chan_c, .fine_gain_chan_d,
		.fine_gain_pct, .driver_swing_chan_a, .driver_swing_chan_b, .rx_equalizer_setting, .gen_nibble,
		.gen_valid);

	always #50 clk_sys = ~clk_sys;

	// One APB transfer, setup then access until pready
	task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d, input logic [3:0] s);
		int k;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0000, d};
		pstrb <= s;
		@(posedge clk_sys);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (pready !== 1'b1) err_total++;
		rd = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Outputs launched by a write settle before callers look
		@(negedge clk_sys);
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		apb(1'b1, a, d, 4'h3);
	endtask : wr

	task automatic rdchk(input string nm, input logic [11:0] a, input logic [15:0] e);
		apb(1'b0, a, 16'h0000, 4'h0);
		`CHK(nm, {16'h0000, e}, rd)
	endtask : rdchk

	task wrap_up;
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : wrap_up

	initial begin
		repeat (20000) @(posedge clk_sys);
		err_total++;
		wrap_up();
	end

	initial begin
		repeat (5) @(posedge clk_sys);
		sys_rst <= 1'b0;
		for (int i = 0; i < 7; i++) rdchk("reset value", ra[i], rv[i]);
		`CHK("tx delay strap", 5'h06, tx_delay_quarter_ns)
		`CHK("rx delay strap", 5'h03, rx_delay_quarter_ns)
		for (int i = 0; i < 7; i++) begin
			wr(ra[i], 16'hFFFF);
			rdchk("write mask", ra[i], wm[i]);
		end
		`CHK("tx delay max", 5'h10, tx_delay_quarter_ns)
		`CHK("rx delay max", 5'h10, rx_delay_quarter_ns)
		`CHK("swing forced", 10'h3FF, {driver_swing_chan_b, driver_swing_chan_a})
		`CHK("gain max", 32'h0E0E0E0E, fine_gain_pct)
		wr(12'h218, 16'h0010);
		`CHK("delay low codes", 10'h041, {tx_delay_quarter_ns, rx_delay_quarter_ns})
		wr(12'h280, 16'h0F00);
		wr(12'h284, 16'h0908);
		`CHK("gain codes", 16'hF089, {fine_gain_chan_b, fine_gain_chan_a, fine_gain_chan_c, fine_gain_chan_d})
		`CHK("gain percent", 32'h02000EF0, fine_gain_pct)
		wr(12'h288, 16'h2105);
		rdchk("swing readback", 12'h288, 16'h2105);
		`CHK("swing a default", 5'h10, driver_swing_chan_a)
		`CHK("swing b forced", 5'h01, driver_swing_chan_b)
		apb(1'b1, 12'h228, 16'hABCD, 4'h1);
		`CHK("eq low strobe", 16'hFFCD, rx_equalizer_setting)
		wr(12'h228, 16'h010F);
		rdchk("eq margin", 12'h228, 16'h010F);
		apb(1'b0, 12'h004, 16'h0000, 4'h0);
		`CHK("unmapped error", 33'h100000000, {serr, rd})
		wr(12'h1EC, 16'h0002);
		wr(12'h1F0, 16'h0002);
		wr(12'h3C0, 16'h0001);
		n = 0;
		while (gen_valid !== 1'b1 && n < 400) begin
			@(posedge clk_sys);
			n++;
		end
		vlen = 0;
		bad = 0;
		while (gen_valid === 1'b1 && vlen < 64) begin
			if (vlen < 14 && gen_nibble !== 4'h5) bad++;
			if (vlen == 14 && gen_nibble !== 4'hD) bad++;
			@(posedge clk_sys);
			vlen++;
		end
		glen = 0;
		while (gen_valid !== 1'b1 && glen < 100) begin
			@(posedge clk_sys);
			glen++;
		end
		`CHK("preamble nibbles", 0, bad)
		`CHK("packet nibbles", 19, vlen)
		`CHK("gap nibbles", 16, glen)
		rdchk("gen status", 12'h3C4, 16'h1001);
		wr(12'h3C0, 16'h0000);
		wrap_up();
	end
endmodule : phy_test_delay_trim_regs_tb

`default_nettype wire
